// file: design/cardbus_bridge_status_busnum.sv
// Card-side status and bus-number configuration registers of a card bridge
// How it works
// - Address or data parity error sets bit 15.
// - Card system error line sets bit 14; never driven.
// - Master abort on own card cycle sets 13.
// - Target abort received on own cycle sets 12.
// - Target abort signalled by us sets 11.
// - Bits 10:9 read fixed 01, medium timing.
// - Bit 8: parity line, bus master, enable.
// - Bit 7 reads zero, no back-to-back.
// - Bit 6 reads zero, no user features.
// - Bit 5 reads zero, card clock slow.
// - Bits 4:0 reserved, read zero.
// - Write one clears a flag; zero keeps.
// - Primary bus number, 8-bit, offset 18h, 00h.
// - Secondary bus number, 8-bit, offset 19h, 00h.
// - Subordinate bus number, offset 1Ah, reset 00h.
// - Secondary and subordinate bus numbers decide configuration cycle forwarding.
// - Each function keeps its own bus numbers.
`timescale 1ns/1ps
`default_nettype none
module cardbus_bridge_status_busnum #(
    parameter int NUM_FUNC = 2
) (
    // Clock and reset
    input  wire logic                      core_clk_i,
    input  wire logic                      srst_i,
    // Configuration register access
    input  wire logic                      cfg_valid_i,
    input  wire logic                      cfg_write_i,
    input  wire logic [$clog2(NUM_FUNC)-1:0] cfg_func_i,
    input  wire logic [5:0]                cfg_dword_i,
    input  wire logic [3:0]                cfg_be_i,
    input  wire logic [31:0]               cfg_wdata_i,
    output logic      [31:0]               cfg_rdata_o,
    output logic                           cfg_ack_o,
    // Card-side pins, active low
    input  wire logic [NUM_FUNC-1:0]       card_system_error_line_n_i,
    input  wire logic [NUM_FUNC-1:0]       card_parity_error_line_n_i,
    // Card data path events, one-cycle pulses; master data phase is a level
    input  wire logic [NUM_FUNC-1:0]       addr_parity_err_i,
    input  wire logic [NUM_FUNC-1:0]       data_parity_err_i,
    input  wire logic [NUM_FUNC-1:0]       master_abort_i,
    input  wire logic [NUM_FUNC-1:0]       target_abort_rcvd_i,
    input  wire logic [NUM_FUNC-1:0]       target_abort_sent_i,
    input  wire logic [NUM_FUNC-1:0]       master_data_phase_i,
    // Bridge control parity response enable
    input  wire logic [NUM_FUNC-1:0]       parity_resp_en_i,
    // Configuration cycle forwarding decode
    input  wire logic                      fwd_valid_i,
    input  wire logic [$clog2(NUM_FUNC)-1:0] fwd_func_i,
    input  wire logic [7:0]                fwd_bus_i,
    output logic                           fwd_done_o,
    output logic                           fwd_local_o,
    output logic                           fwd_onward_o,
    // Status flags per function
    output logic      [NUM_FUNC-1:0]       card_error_any_o
);
    import cb_status_pkg::*;

    localparam int FW = $clog2(NUM_FUNC);

    // Synchronised pins, still active low, and their asserted-high forms
    logic [NUM_FUNC-1:0] serr_line_n_s;
    logic [NUM_FUNC-1:0] perr_line_n_s;
    logic [NUM_FUNC-1:0] serr_seen;
    logic [NUM_FUNC-1:0] perr_seen;

    // Pins idle high; reset value matches so no false event at release
    pin_sync2 #(
        .WIDTH     (NUM_FUNC),
        .RESET_VAL (32'hffff_ffff)
    ) u_serr_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (card_system_error_line_n_i),
        .sync_o     (serr_line_n_s)
    );

    pin_sync2 #(
        .WIDTH     (NUM_FUNC),
        .RESET_VAL (32'hffff_ffff)
    ) u_perr_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (card_parity_error_line_n_i),
        .sync_o     (perr_line_n_s)
    );

    assign serr_seen = ~serr_line_n_s;
    assign perr_seen = ~perr_line_n_s;

    // Per-function state
    logic [NUM_FUNC-1:0] card_parity_detected;
    logic [NUM_FUNC-1:0] card_sys_error_seen;
    logic [NUM_FUNC-1:0] master_abort_received;
    logic [NUM_FUNC-1:0] target_abort_received;
    logic [NUM_FUNC-1:0] target_abort_signaled;
    logic [NUM_FUNC-1:0] master_data_parity_flag;
    logic [NUM_FUNC-1:0] next_card_parity_detected;
    logic [NUM_FUNC-1:0] next_card_sys_error_seen;
    logic [NUM_FUNC-1:0] next_master_abort_received;
    logic [NUM_FUNC-1:0] next_target_abort_received;
    logic [NUM_FUNC-1:0] next_target_abort_signaled;
    logic [NUM_FUNC-1:0] next_master_data_parity_flag;
    logic [NUM_FUNC-1:0] next_card_error_any;

    logic [7:0]  prim_id [NUM_FUNC];
    logic [7:0]  sec_id  [NUM_FUNC];
    logic [7:0]  sub_id  [NUM_FUNC];
    logic [15:0] status_word [NUM_FUNC];

    // Access decode shared by all functions
    logic status_hit;
    logic bus_ids_hit;
    logic status_wr;

    assign status_hit  = cfg_valid_i && (cfg_dword_i == DW_CARD_STATUS);
    assign bus_ids_hit = cfg_valid_i && (cfg_dword_i == DW_BUS_IDS);
    assign status_wr   = status_hit && cfg_write_i;

    // One copy of flags, status image and bus numbers per function
    genvar f;
    generate
        for (f = 0; f < NUM_FUNC; f++) begin : g_func
            bus_id_if bus ();
            logic       sel;
            logic [7:0] clr_lo;
            logic [7:0] clr_hi;

            assign sel = (cfg_func_i == FW'(f));

            // Independent copy of the bus numbers for this function
            fn_bus_ids u_ids (
                .core_clk_i (core_clk_i),
                .srst_i     (srst_i),
                .bus        (bus.regs)
            );

            assign bus.wr_primary      = bus_ids_hit && cfg_write_i && sel
                                         && cfg_be_i[LANE_PRIMARY];
            assign bus.wr_secondary    = bus_ids_hit && cfg_write_i && sel
                                         && cfg_be_i[LANE_SECONDARY];
            assign bus.wr_subord       = bus_ids_hit && cfg_write_i && sel
                                         && cfg_be_i[LANE_SUBORD];
            assign bus.wdata_primary   = cfg_wdata_i[LANE_PRIMARY*8 +: 8];
            assign bus.wdata_secondary = cfg_wdata_i[LANE_SECONDARY*8 +: 8];
            assign bus.wdata_subord    = cfg_wdata_i[LANE_SUBORD*8 +: 8];
            assign prim_id[f]          = bus.primary_bus_id;
            assign sec_id[f]           = bus.secondary_bus_id;
            assign sub_id[f]           = bus.subordinate_bus_id;

            // Write-one-to-clear masks per byte lane
            assign clr_lo = (status_wr && sel && cfg_be_i[LANE_STATUS_LO])
                            ? cfg_wdata_i[LANE_STATUS_LO*8 +: 8] : 8'h00;
            assign clr_hi = (status_wr && sel && cfg_be_i[LANE_STATUS_HI])
                            ? cfg_wdata_i[LANE_STATUS_HI*8 +: 8] : 8'h00;

            // A new event in the clearing cycle keeps its flag set
            always_comb begin
                next_card_parity_detected[f] =
                    (card_parity_detected[f] & ~clr_hi[BIT_PARITY_DETECTED-8])
                    | addr_parity_err_i[f] | data_parity_err_i[f];
                // Input only: this block has no drive path for that line
                next_card_sys_error_seen[f] =
                    (card_sys_error_seen[f] & ~clr_hi[BIT_SYS_ERROR_SEEN-8])
                    | serr_seen[f];
                next_master_abort_received[f] =
                    (master_abort_received[f] & ~clr_hi[BIT_MABORT_RECEIVED-8])
                    | master_abort_i[f];
                next_target_abort_received[f] =
                    (target_abort_received[f] & ~clr_hi[BIT_TABORT_RECEIVED-8])
                    | target_abort_rcvd_i[f];
                next_target_abort_signaled[f] =
                    (target_abort_signaled[f] & ~clr_hi[BIT_TABORT_SIGNALED-8])
                    | target_abort_sent_i[f];
                next_master_data_parity_flag[f] =
                    (master_data_parity_flag[f] & ~clr_hi[BIT_MASTER_DPAR-8])
                    | (perr_seen[f] & master_data_phase_i[f]
                       & parity_resp_en_i[f]);
                next_card_error_any[f] =
                    next_card_parity_detected[f] | next_card_sys_error_seen[f]
                    | next_master_abort_received[f] | next_target_abort_received[f]
                    | next_target_abort_signaled[f] | next_master_data_parity_flag[f];
            end

            always_comb begin
                status_word[f]                      = 16'h0000;
                status_word[f][BIT_PARITY_DETECTED] = card_parity_detected[f];
                status_word[f][BIT_SYS_ERROR_SEEN]  = card_sys_error_seen[f];
                status_word[f][BIT_MABORT_RECEIVED] = master_abort_received[f];
                status_word[f][BIT_TABORT_RECEIVED] = target_abort_received[f];
                status_word[f][BIT_TABORT_SIGNALED] = target_abort_signaled[f];
                status_word[f][BIT_SEL_TIMING_HI:BIT_SEL_TIMING_LO] =
                    SELECT_TIMING_CODE;
                status_word[f][BIT_MASTER_DPAR]     = master_data_parity_flag[f];
                status_word[f][BIT_BACK_TO_BACK]    = BACK_TO_BACK_CAP;
                status_word[f][BIT_USER_FEATURE]    = USER_FEATURE_SUP;
                status_word[f][BIT_HIGH_SPEED]      = HIGH_SPEED_CAP;
                status_word[f][4:0]                 = STATUS_RSVD_VALUE;
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            card_parity_detected    <= '0;
            card_sys_error_seen     <= '0;
            master_abort_received   <= '0;
            target_abort_received   <= '0;
            target_abort_signaled   <= '0;
            master_data_parity_flag <= '0;
            card_error_any_o        <= '0;
        end else begin
            card_parity_detected    <= next_card_parity_detected;
            card_sys_error_seen     <= next_card_sys_error_seen;
            master_abort_received   <= next_master_abort_received;
            target_abort_received   <= next_target_abort_received;
            target_abort_signaled   <= next_target_abort_signaled;
            master_data_parity_flag <= next_master_data_parity_flag;
            card_error_any_o        <= next_card_error_any;
        end
    end

    // Read path; unmapped dwords and byte 1Bh return zero
    logic [15:0] rd_status;
    logic [7:0]  rd_prim;
    logic [7:0]  rd_sec;
    logic [7:0]  rd_sub;
    logic [31:0] next_cfg_rdata;
    logic        next_cfg_ack;

    // One mux per register keeps the lane placement below easy to audit
    assign rd_status = status_word[cfg_func_i];
    assign rd_prim   = prim_id[cfg_func_i];
    assign rd_sec    = sec_id[cfg_func_i];
    assign rd_sub    = sub_id[cfg_func_i];

    always_comb begin
        next_cfg_rdata = 32'h0000_0000;
        next_cfg_ack   = cfg_valid_i;
        if (cfg_valid_i && !cfg_write_i) begin
            if (cfg_dword_i == DW_CARD_STATUS) begin
                next_cfg_rdata[LANE_STATUS_LO*8 +: 16] = rd_status;
            end else if (cfg_dword_i == DW_BUS_IDS) begin
                next_cfg_rdata[LANE_PRIMARY*8 +: 8]   = rd_prim;
                next_cfg_rdata[LANE_SECONDARY*8 +: 8] = rd_sec;
                next_cfg_rdata[LANE_SUBORD*8 +: 8]    = rd_sub;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_ack_o   <= 1'b0;
        end else begin
            cfg_rdata_o <= next_cfg_rdata;
            cfg_ack_o   <= next_cfg_ack;
        end
    end

    // Forwarding decode; an empty range (subordinate below secondary)
    // simply never matches onward, so stale programming cannot loop
    logic [7:0] fwd_sec;
    logic [7:0] fwd_sub;
    logic       fwd_is_sec;
    logic       fwd_in_range;
    logic       next_fwd_done;
    logic       next_fwd_local;
    logic       next_fwd_onward;

    // Numbers of the function named by the request; the primary number
    // only places the bridge upstream and takes no part here
    assign fwd_sec      = sec_id[fwd_func_i];
    assign fwd_sub      = sub_id[fwd_func_i];
    assign fwd_is_sec   = (fwd_bus_i == fwd_sec);
    assign fwd_in_range = (fwd_bus_i > fwd_sec) && (fwd_bus_i <= fwd_sub);

    always_comb begin
        next_fwd_done   = fwd_valid_i;
        next_fwd_local  = 1'b0;
        next_fwd_onward = 1'b0;
        if (fwd_valid_i) begin
            next_fwd_local  = fwd_is_sec;
            next_fwd_onward = fwd_in_range;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            fwd_done_o   <= 1'b0;
            fwd_local_o  <= 1'b0;
            fwd_onward_o <= 1'b0;
        end else begin
            fwd_done_o   <= next_fwd_done;
            fwd_local_o  <= next_fwd_local;
            fwd_onward_o <= next_fwd_onward;
        end
    end
endmodule
`default_nettype wire

// file: design/cb_status_pkg.sv
// Shared constants for the card-side status and bus-number register slice
package cb_status_pkg;

    // Configuration byte offsets
    localparam logic [7:0] OFS_CARD_STATUS   = 8'h16;
    localparam logic [7:0] OFS_PRIMARY_BUS   = 8'h18;
    localparam logic [7:0] OFS_SECONDARY_BUS = 8'h19;
    localparam logic [7:0] OFS_SUBORD_BUS    = 8'h1a;

    // Dword indices derived from the byte offsets
    localparam logic [5:0] DW_CARD_STATUS = OFS_CARD_STATUS[7:2];
    localparam logic [5:0] DW_BUS_IDS     = OFS_PRIMARY_BUS[7:2];

    // Byte lanes within a dword
    localparam int LANE_STATUS_LO = OFS_CARD_STATUS[1:0];
    localparam int LANE_STATUS_HI = OFS_CARD_STATUS[1:0] + 1;
    localparam int LANE_PRIMARY   = OFS_PRIMARY_BUS[1:0];
    localparam int LANE_SECONDARY = OFS_SECONDARY_BUS[1:0];
    localparam int LANE_SUBORD    = OFS_SUBORD_BUS[1:0];

    // Card-side status field positions
    localparam int BIT_PARITY_DETECTED  = 15;
    localparam int BIT_SYS_ERROR_SEEN   = 14;
    localparam int BIT_MABORT_RECEIVED  = 13;
    localparam int BIT_TABORT_RECEIVED  = 12;
    localparam int BIT_TABORT_SIGNALED  = 11;
    localparam int BIT_SEL_TIMING_HI    = 10;
    localparam int BIT_SEL_TIMING_LO    = 9;
    localparam int BIT_MASTER_DPAR      = 8;
    localparam int BIT_BACK_TO_BACK     = 7;
    localparam int BIT_USER_FEATURE     = 6;
    localparam int BIT_HIGH_SPEED       = 5;

    // Fixed fields and reset values
    localparam logic [1:0]  SELECT_TIMING_CODE  = 2'h1;
    localparam logic        BACK_TO_BACK_CAP    = 1'b0;
    localparam logic        USER_FEATURE_SUP    = 1'b0;
    localparam logic        HIGH_SPEED_CAP      = 1'b0;
    localparam logic [4:0]  STATUS_RSVD_VALUE   = 5'h00;
    localparam logic [7:0]  BUS_ID_RESET        = 8'h00;
    localparam logic [15:0] CARD_STATUS_RESET   = 16'h0200;

endpackage

// file: design/bus_id_if.sv
// Carrier between the top and a per-function bus-number register set
`timescale 1ns/1ps
`default_nettype none
interface bus_id_if;
    logic       wr_primary;
    logic       wr_secondary;
    logic       wr_subord;
    logic [7:0] wdata_primary;
    logic [7:0] wdata_secondary;
    logic [7:0] wdata_subord;
    logic [7:0] primary_bus_id;
    logic [7:0] secondary_bus_id;
    logic [7:0] subordinate_bus_id;

    modport ctrl (
        output wr_primary, wr_secondary, wr_subord,
        output wdata_primary, wdata_secondary, wdata_subord,
        input  primary_bus_id, secondary_bus_id, subordinate_bus_id
    );
    modport regs (
        input  wr_primary, wr_secondary, wr_subord,
        input  wdata_primary, wdata_secondary, wdata_subord,
        output primary_bus_id, secondary_bus_id, subordinate_bus_id
    );
endinterface
`default_nettype wire

// file: design/pin_sync2.sv
// Two-flop synchroniser for card-side pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
    parameter int          WIDTH     = 1,
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] next_stable;

    // First stage feeds only the second stage
    always_comb begin
        next_meta   = async_i;
        next_stable = meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            meta   <= RESET_VAL[WIDTH-1:0];
            stable <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
        end
    end

    assign sync_o = stable;
endmodule
`default_nettype wire

// file: design/fn_bus_ids.sv
// Primary, secondary and subordinate bus-number registers of one function
`timescale 1ns/1ps
`default_nettype none
module fn_bus_ids (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    // Register access
    bus_id_if.regs    bus
);
    import cb_status_pkg::*;

    logic [7:0] primary_q;
    logic [7:0] secondary_q;
    logic [7:0] subord_q;
    logic [7:0] next_primary;
    logic [7:0] next_secondary;
    logic [7:0] next_subord;

    always_comb begin
        next_primary   = bus.wr_primary   ? bus.wdata_primary   : primary_q;
        next_secondary = bus.wr_secondary ? bus.wdata_secondary : secondary_q;
        next_subord    = bus.wr_subord    ? bus.wdata_subord    : subord_q;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            primary_q   <= BUS_ID_RESET;
            secondary_q <= BUS_ID_RESET;
            subord_q    <= BUS_ID_RESET;
        end else begin
            primary_q   <= next_primary;
            secondary_q <= next_secondary;
            subord_q    <= next_subord;
        end
    end

    assign bus.primary_bus_id     = primary_q;
    assign bus.secondary_bus_id   = secondary_q;
    assign bus.subordinate_bus_id = subord_q;
endmodule
`default_nettype wire

// file: testbench/cb_status_sva.sv
// Concurrent checks on the card-side status and bus-number slice
`timescale 1ns/1ps
`default_nettype none
module cb_status_sva
    import cb_status_pkg::*;
#(
    parameter int NUM_FUNC = 2
) (
    // Clock and reset
    input wire logic                core_clk_i,
    input wire logic                srst_i,
    // Configuration access
    input wire logic                cfg_valid_i,
    input wire logic                cfg_write_i,
    input wire logic [5:0]          cfg_dword_i,
    input wire logic [31:0]         cfg_rdata_o,
    input wire logic                cfg_ack_o,
    // Card events
    input wire logic [NUM_FUNC-1:0] master_abort_i,
    input wire logic [NUM_FUNC-1:0] target_abort_sent_i,
    // Forwarding and summary
    input wire logic                fwd_valid_i,
    input wire logic                fwd_done_o,
    input wire logic                fwd_local_o,
    input wire logic                fwd_onward_o,
    input wire logic [NUM_FUNC-1:0] card_error_any_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    a_ack_follows: assert property (cfg_valid_i |=> cfg_ack_o)
        else $error("config access not acknowledged");
    a_ack_quiet: assert property (!cfg_valid_i |=> !cfg_ack_o && cfg_rdata_o == 32'h0)
        else $error("config answer without request");
    a_fixed_bits: assert property (cfg_ack_o && $past(cfg_valid_i && !cfg_write_i
        && cfg_dword_i == DW_CARD_STATUS) |-> {cfg_rdata_o[26:25], cfg_rdata_o[23:16]} == 10'h100)
        else $error("fixed status fields wrong");
    a_write_silent: assert property (cfg_valid_i && cfg_write_i |=> cfg_rdata_o == 32'h0)
        else $error("write returned read data");
    a_abort_sets: assert property (master_abort_i[0] |=> card_error_any_o[0])
        else $error("master abort did not set a flag");
    a_signal_sets: assert property (target_abort_sent_i[NUM_FUNC-1] |=> card_error_any_o[NUM_FUNC-1])
        else $error("signalled abort did not set a flag");
    a_flag_holds: assert property (card_error_any_o[0] && !(cfg_valid_i && cfg_write_i)
        |=> card_error_any_o[0])
        else $error("error flag dropped without a clear");
    a_fwd_answer: assert property (fwd_valid_i |=> fwd_done_o)
        else $error("forward decode not answered");
    a_fwd_idle: assert property (!fwd_valid_i |=> !fwd_done_o && !fwd_local_o && !fwd_onward_o)
        else $error("forward result without request");
endmodule
bind cardbus_bridge_status_busnum cb_status_sva #(.NUM_FUNC(NUM_FUNC)) i_cb_status_sva (
    .core_clk_i, .srst_i, .cfg_valid_i, .cfg_write_i, .cfg_dword_i, .cfg_rdata_o, .cfg_ack_o,
    .master_abort_i, .target_abort_sent_i, .fwd_valid_i, .fwd_done_o, .fwd_local_o,
    .fwd_onward_o, .card_error_any_o);
`default_nettype wire

// file: testbench/card_socket_model.sv
// Card socket stand-in: card error pins and card data path events
`timescale 1ns/1ps
`default_nettype none
module card_socket_model #(
    parameter int NUM_FUNC = 2
) (
    // Clock
    input  wire logic                     core_clk_i,
    // Card pins, active low
    output var logic [NUM_FUNC-1:0]       serr_n_o,
    output var logic [NUM_FUNC-1:0]       perr_n_o,
    // Data path events and levels
    output var logic [4:0][NUM_FUNC-1:0]  event_o,
    output var logic [NUM_FUNC-1:0]       master_phase_o,
    output var logic [NUM_FUNC-1:0]       resp_en_o
);
    // Lines are pulled up, so idle reads high
    initial begin
        serr_n_o = '1;
        perr_n_o = '1;
        event_o = '0;
        master_phase_o = '0;
        resp_en_o = '0;
    end
    // One-cycle pulse, launched off the sampling edge
    task automatic pulse(input int kind, input int fn);
        @(negedge core_clk_i);
        event_o[kind][fn] = 1'b1;
        @(negedge core_clk_i);
        event_o[kind][fn] = 1'b0;
    endtask
    // Only the card drives its error lines; the bridge just listens
    task automatic pins(input int fn, input logic se, pe, mp, re);
        @(negedge core_clk_i);
        serr_n_o[fn] = se;
        perr_n_o[fn] = pe;
        master_phase_o[fn] = mp;
        resp_en_o[fn] = re;
    endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the card-side status and bus-number slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, g, e); end end
module testbench;
    import cb_status_pkg::*;
    localparam logic [31:0] S0 = {CARD_STATUS_RESET, 16'h0};
    logic             core_clk_i = 0;
    logic             srst_i = 1;
    logic             cfg_valid_i = 0;
    logic             cfg_write_i = 0;
    logic [0:0]       cfg_func_i = 0;
    logic [5:0]       cfg_dword_i = 0;
    logic [3:0]       cfg_be_i = 0;
    logic [31:0]      cfg_wdata_i = 0;
    logic [31:0]      cfg_rdata_o;
    logic             cfg_ack_o;
    logic             fwd_valid_i = 0;
    logic [0:0]       fwd_func_i = 0;
    logic [7:0]       fwd_bus_i = 0;
    logic             fwd_done_o;
    logic             fwd_local_o;
    logic             fwd_onward_o;
    logic [1:0]       serr_n, perr_n, mph, ren, card_error_any_o;
    logic [4:0][1:0]  ev;
    int               fails = 0;
    int               samples_checked = 0;
    int               pos[5] = '{15, 15, 13, 12, 11};
    logic [7:0]       buses[6] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h1f, 8'h10};
    logic [1:0]       kinds[6] = '{2'b10, 2'b01, 2'b01, 2'b00, 2'b00, 2'b00};

    always #2.5 core_clk_i = ~core_clk_i;

    cardbus_bridge_status_busnum #(.NUM_FUNC(2)) i_cardbus_bridge_status_busnum (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .cfg_valid_i(cfg_valid_i),
        .cfg_write_i(cfg_write_i), .cfg_func_i(cfg_func_i), .cfg_dword_i(cfg_dword_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_ack_o(cfg_ack_o), .card_system_error_line_n_i(serr_n),
        .card_parity_error_line_n_i(perr_n), .addr_parity_err_i(ev[0]),
        .data_parity_err_i(ev[1]), .master_abort_i(ev[2]), .target_abort_rcvd_i(ev[3]),
        .target_abort_sent_i(ev[4]), .master_data_phase_i(mph), .parity_resp_en_i(ren),
        .fwd_valid_i(fwd_valid_i), .fwd_func_i(fwd_func_i), .fwd_bus_i(fwd_bus_i),
        .fwd_done_o(fwd_done_o), .fwd_local_o(fwd_local_o), .fwd_onward_o(fwd_onward_o),
        .card_error_any_o(card_error_any_o));

    card_socket_model #(.NUM_FUNC(2)) i_card_socket_model (
        .core_clk_i(core_clk_i), .serr_n_o(serr_n), .perr_n_o(perr_n), .event_o(ev),
        .master_phase_o(mph), .resp_en_o(ren));

    // One access; writes answer with zero data
    task automatic acc(input logic w, f, input logic [5:0] dw, input logic [3:0] be,
                       input logic [31:0] wd, ex);
        @(negedge core_clk_i);
        cfg_valid_i = 1;
        cfg_write_i = w;
        cfg_func_i = f;
        cfg_dword_i = dw;
        cfg_be_i = be;
        cfg_wdata_i = wd;
        @(negedge core_clk_i);
        cfg_valid_i = 0;
        `CHK({cfg_ack_o, cfg_rdata_o}, {1'b1, ex})
    endtask

    task automatic fwd(input logic f, input logic [7:0] b, input logic [1:0] ex);
        @(negedge core_clk_i);
        fwd_valid_i = 1;
        fwd_func_i = f;
        fwd_bus_i = b;
        @(negedge core_clk_i);
        fwd_valid_i = 0;
        `CHK({fwd_done_o, fwd_local_o, fwd_onward_o}, {1'b1, ex})
    endtask

    // Clearing every flag bit also writes the fixed ones, which must ignore it
    task automatic clr(input logic f);
        acc(1, f, 5, 4'hc, 32'hffff_0000, 0);
        acc(0, f, 5, 0, 0, S0);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk_i);
        fails++;
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge core_clk_i);
        @(negedge core_clk_i);
        srst_i = 0;
        for (int f = 0; f < 2; f++) begin
            acc(0, f, 5, 0, 0, S0);
            acc(0, f, 6, 0, 0, 0);
        end
        acc(0, 0, 7, 0, 0, 0);
        done("reset");
        for (int k = 0; k < 5; k++) begin
            i_card_socket_model.pulse(k, 1);
            `CHK(card_error_any_o, 2'b10)
            acc(1, 1, 5, 4'hc, 0, 0);
            acc(0, 1, 5, 0, 0, S0 | (32'h1 << (16 + pos[k])));
            acc(0, 0, 5, 0, 0, S0);
            clr(1);
            `CHK(card_error_any_o, 2'b00)
        end
        i_card_socket_model.pulse(2, 0);
        acc(0, 0, 5, 0, 0, S0 | 32'h2000_0000);
        clr(0);
        done("events");
        i_card_socket_model.pins(0, 0, 1, 0, 0);
        repeat (4) @(negedge core_clk_i);
        acc(0, 0, 5, 0, 0, S0 | 32'h4000_0000);
        acc(0, 1, 5, 0, 0, S0);
        i_card_socket_model.pins(0, 1, 1, 0, 0);
        repeat (3) @(negedge core_clk_i);
        clr(0);
        i_card_socket_model.pins(1, 1, 0, 1, 0);
        repeat (4) @(negedge core_clk_i);
        acc(0, 1, 5, 0, 0, S0);
        i_card_socket_model.pins(1, 1, 0, 1, 1);
        repeat (4) @(negedge core_clk_i);
        acc(0, 1, 5, 0, 0, S0 | 32'h0100_0000);
        i_card_socket_model.pins(1, 1, 1, 0, 0);
        repeat (3) @(negedge core_clk_i);
        clr(1);
        done("pins");
        acc(1, 0, 6, 4'hf, 32'hff30_2010, 0);
        acc(1, 1, 6, 4'h7, 32'h0077_6655, 0);
        acc(1, 1, 6, 4'h2, 32'hffff_88ff, 0);
        acc(0, 0, 6, 0, 0, 32'h0030_2010);
        acc(0, 1, 6, 0, 0, 32'h0077_8855);
        done("bus numbers");
        for (int i = 0; i < 6; i++)
            fwd(0, buses[i], kinds[i]);
        fwd(1, 8'h88, 2'b10);
        fwd(1, 8'h89, 2'b00);
        done("forwarding");
        tally_and_finish;
    end
endmodule
`default_nettype wire
